// File: design/cpoc_pkg.sv
// Package for the compare output-control stage: register map, fields, state carrier
package cpoc_pkg;

  // Multi-output variant carries mode, B/D/F polarity and B/D/F shutdown fields
  localparam logic        MULTI_OUTPUT   = 1'b1;

  localparam logic [7:0]  ADDR_CTRL      = 8'h00;
  localparam logic [7:0]  ADDR_STATUS    = 8'h04;

  localparam int          HOLD_BIT       = 15;
  localparam int          OSC_LSB        = 12;
  localparam int          MODE_LSB       = 8;
  localparam int          POL_ACE_BIT    = 5;
  localparam int          POL_BDF_BIT    = 4;
  localparam int          SSA_LSB        = 2;
  localparam int          SSB_LSB        = 0;

  localparam logic [15:0] CTRL_RESET     = 16'h0000;
  localparam logic [15:0] CTRL_WMASK     = MULTI_OUTPUT ? 16'hf73f : 16'hf02c;

  localparam logic [2:0]  MODE_SINGLE    = 3'h0;
  localparam logic [2:0]  MODE_PUSHPULL  = 3'h1;
  localparam logic [2:0]  MODE_HALF      = 3'h2;
  localparam logic [2:0]  MODE_BDC_REV   = 3'h4;
  localparam logic [2:0]  MODE_BDC_FWD   = 3'h5;
  localparam logic [2:0]  MODE_SCAN      = 3'h6;
  localparam logic [2:0]  MODE_RESERVED  = 3'h7;
  localparam logic [2:0]  SCAN_LAST      = 3'h5;

  localparam logic [1:0]  SHUT_ACTIVE    = 2'h3;
  localparam logic [1:0]  SHUT_INACTIVE  = 2'h2;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic [5:0] level;
    logic [5:0] oe_n;
  } cpoc_pins_t;

  typedef struct packed {
    logic [15:0] ctrl;
    logic        triggered;
    logic        os_active;
    logic [2:0]  os_rem;
    logic        pp_phase;
    logic [2:0]  scan_idx;
    logic        shut_active;
    cpoc_pins_t  pins;
    logic        awready;
    logic        wready;
    logic        aw_got;
    logic        w_got;
    logic [7:0]  waddr;
    logic [15:0] wdata;
    logic [1:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
  } cpoc_state_t;

endpackage

// File: design/cpoc_output_control.sv
// Output-control stage of a compare/PWM unit with an AXI4-Lite register slave
//
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - With hold bit set in triggered mode and no shutdown, enabled pins stay undriven until a trigger.
// - Mode field picks single, push-pull, half-bridge, brush DC, scan; 111 reserved.
// - Each group polarity bit makes its A/C/E or B/D/F pins active-low when set.
// - On shutdown A/C/E pins go active for 11, inactive for 10, tri-state for 0x.
// - On shutdown B/D/F pins go inactive for 10, high impedance for 0x.
// - Mode, B/D/F polarity and B/D/F shutdown fields exist only in multi-output variant.
module cpoc_output_control
  import cpoc_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output var  logic              s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output var  logic              s_axi_wready,
  output var  logic [1:0]        s_axi_bresp,
  output var  logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output var  logic              s_axi_arready,
  output var  logic [31:0]       s_axi_rdata,
  output var  logic [1:0]        s_axi_rresp,
  output var  logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              time_base_tick,
  input  wire logic              pwm_level,
  input  wire logic              one_shot_start,
  input  wire logic              triggered_mode_enable,
  input  wire logic              trigger_in,
  input  wire logic              shutdown_in,
  output var  cpoc_pkg::cpoc_pins_t pins,
  output var  logic              one_shot_active
);
  import cpoc_pkg::*;

  cpoc_state_t st_reg;
  cpoc_state_t st_next;

  // Shutdown drive for one pin group: bit 1 is level, bit 0 is oe_n
  function automatic logic [1:0] shut_drive(input logic [1:0] code, input logic pol);
    if (code == SHUT_ACTIVE) begin
      shut_drive = {~pol, 1'b0};
    end else if (code == SHUT_INACTIVE) begin
      shut_drive = {pol, 1'b0};
    end else begin
      shut_drive = {pol, 1'b1};
    end
  endfunction

  logic [2:0]  mode;
  logic [2:0]  osc;
  logic        hold_en;
  logic        pol_ace;
  logic        pol_bdf;
  logic [1:0]  ssa;
  logic [1:0]  ssb;
  logic        hold_off;
  logic        take_aw;
  logic        take_w;
  logic [7:0]  wr_addr;
  logic [15:0] wr_data;
  logic [1:0]  wr_strb;
  logic [5:0]  act;
  logic [5:0]  drv;
  logic [1:0]  sa;
  logic [1:0]  sb;

  assign mode    = st_reg.ctrl[MODE_LSB +: 3];
  assign osc     = st_reg.ctrl[OSC_LSB +: 3];
  assign hold_en = st_reg.ctrl[HOLD_BIT];
  assign pol_ace = st_reg.ctrl[POL_ACE_BIT];
  assign pol_bdf = st_reg.ctrl[POL_BDF_BIT];
  assign ssa     = st_reg.ctrl[SSA_LSB +: 2];
  assign ssb     = st_reg.ctrl[SSB_LSB +: 2];
  assign hold_off = hold_en && triggered_mode_enable && !st_reg.triggered;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_next = st_reg;
    act     = 6'h00;
    drv     = 6'h00;
    sa      = 2'h0;
    sb      = 2'h0;

    // Register bus: address and data are taken in either order
    take_aw = s_axi_awvalid && st_reg.awready;
    take_w  = s_axi_wvalid && st_reg.wready;
    if (take_aw) begin
      st_next.aw_got = 1'b1;
      st_next.waddr  = s_axi_awaddr;
    end
    if (take_w) begin
      st_next.w_got = 1'b1;
      st_next.wdata = s_axi_wdata[15:0];
      st_next.wstrb = s_axi_wstrb[1:0];
    end
    wr_addr = take_aw ? s_axi_awaddr : st_reg.waddr;
    wr_data = take_w ? s_axi_wdata[15:0] : st_reg.wdata;
    wr_strb = take_w ? s_axi_wstrb[1:0] : st_reg.wstrb;
    if (st_next.aw_got && st_next.w_got) begin
      st_next.aw_got = 1'b0;
      st_next.w_got  = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp  = RESP_OKAY;
      if (wr_addr[7:2] == ADDR_CTRL[7:2]) begin
        // Bits absent from this variant never take a write
        if (wr_strb[0]) begin
          st_next.ctrl[7:0] = wr_data[7:0] & CTRL_WMASK[7:0];
        end
        if (wr_strb[1]) begin
          st_next.ctrl[15:8] = wr_data[15:8] & CTRL_WMASK[15:8];
        end
      end else if (wr_addr[7:2] != ADDR_STATUS[7:2]) begin
        st_next.bresp = RESP_SLVERR;
      end
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end
    st_next.awready = !st_next.aw_got && !st_next.bvalid;
    st_next.wready  = !st_next.w_got && !st_next.bvalid;

    if (s_axi_arvalid && st_reg.arready) begin
      st_next.rvalid = 1'b1;
      st_next.rresp  = RESP_OKAY;
      st_next.rdata  = 32'h0000_0000;
      if (s_axi_araddr[7:2] == ADDR_CTRL[7:2]) begin
        st_next.rdata[15:0] = st_reg.ctrl;
      end else if (s_axi_araddr[7:2] == ADDR_STATUS[7:2]) begin
        st_next.rdata[21:0] = {st_reg.shut_active, st_reg.triggered, st_reg.os_active,
                               st_reg.os_rem, st_reg.pins.level, st_reg.pins.oe_n, st_reg.scan_idx, st_reg.pp_phase};
      end else begin
        st_next.rresp = RESP_SLVERR;
      end
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
    st_next.arready = !st_next.rvalid;

    // Trigger latch; a trigger in the same cycle as leaving triggered mode still wins
    if (trigger_in) begin
      st_next.triggered = 1'b1;
    end else if (!triggered_mode_enable) begin
      st_next.triggered = 1'b0;
    end

    // One-shot stretch; a restart while running is ignored
    if (!st_reg.os_active) begin
      if (one_shot_start) begin
        st_next.os_active = 1'b1;
        st_next.os_rem    = osc;
      end
    end else if (time_base_tick) begin
      if (st_reg.os_rem == 3'h0) begin
        st_next.os_active = 1'b0;
      end else begin
        st_next.os_rem = st_reg.os_rem - 3'h1;
      end
    end

    if (time_base_tick) begin
      st_next.pp_phase = !st_reg.pp_phase;
      st_next.scan_idx = (st_reg.scan_idx == SCAN_LAST) ? 3'h0 : st_reg.scan_idx + 3'h1;
    end

    // Nominal activity per pin: A=0, B=1, C=2, D=3, E=4, F=5
    case (mode)
      MODE_SINGLE: begin
        drv    = 6'h01;
        act[0] = pwm_level;
      end
      MODE_PUSHPULL: begin
        drv    = 6'h03;
        act[0] = pwm_level && !st_reg.pp_phase;
        act[1] = pwm_level && st_reg.pp_phase;
      end
      MODE_HALF: begin
        drv    = 6'h03;
        act[0] = pwm_level;
        act[1] = !pwm_level;
      end
      MODE_BDC_REV: begin
        drv    = 6'h0f;
        act[2] = 1'b1;
        act[1] = pwm_level;
      end
      MODE_BDC_FWD: begin
        drv    = 6'h0f;
        act[0] = 1'b1;
        act[3] = pwm_level;
      end
      MODE_SCAN: begin
        drv               = 6'h3f;
        act[st_reg.scan_idx] = pwm_level;
      end
      default: begin
        // Reserved code leaves every pin undriven
        drv = 6'h00;
      end
    endcase

    st_next.shut_active = shutdown_in;
    sa = shut_drive(ssa, pol_ace);
    sb = shut_drive(ssb, pol_bdf);
    for (int i = 0; i < 6; i++) begin
      if (shutdown_in) begin
        // Registered, so the shutdown state lands on the edge after detection
        st_next.pins.level[i] = i[0] ? sb[1] : sa[1];
        st_next.pins.oe_n[i]  = i[0] ? sb[0] : sa[0];
      end else begin
        st_next.pins.level[i] = act[i] ^ (i[0] ? pol_bdf : pol_ace);
        st_next.pins.oe_n[i]  = !drv[i] || hold_off;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg <= '0;
      st_reg.ctrl <= CTRL_RESET;
      st_reg.pins.oe_n <= 6'h3f;
    end else begin
      st_reg <= st_next;
    end
  end

  assign s_axi_awready   = st_reg.awready;
  assign s_axi_wready    = st_reg.wready;
  assign s_axi_bvalid    = st_reg.bvalid;
  assign s_axi_bresp     = st_reg.bresp;
  assign s_axi_arready   = st_reg.arready;
  assign s_axi_rvalid    = st_reg.rvalid;
  assign s_axi_rresp     = st_reg.rresp;
  assign s_axi_rdata     = st_reg.rdata;
  assign pins            = st_reg.pins;
  assign one_shot_active = st_reg.os_active;

  ////////////////////////////////////////////////////////////////////////////////
  // Helper: ticks counted over one one-shot event, and the count it started with
  logic [3:0] os_ticks_reg;
  logic [2:0] os_len_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      os_ticks_reg <= 4'h0;
      os_len_reg   <= 3'h0;
    end else if (!st_reg.os_active && one_shot_start) begin
      os_ticks_reg <= 4'h0;
      os_len_reg   <= osc;
    end else if (st_reg.os_active && time_base_tick) begin
      os_ticks_reg <= os_ticks_reg + 4'h1;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hold_pins_off: assert property (hold_off && !shutdown_in |=> pins.oe_n == 6'h3f)
    else $error("Pins driven while held for trigger");
  a_oneshot_length: assert property ($fell(st_reg.os_active) |-> os_ticks_reg == {1'b0, os_len_reg} + 4'h1)
    else $error("One-shot length differs from count plus one");
  a_mode_reserved: assert property (mode == MODE_RESERVED && !shutdown_in |=> pins.oe_n == 6'h3f)
    else $error("Reserved mode drives a pin");
  a_half_bridge_pair: assert property (mode == MODE_HALF && !shutdown_in && !hold_off
    |=> (pins.level[0] ^ pins.level[1]) == !($past(pol_ace) ^ $past(pol_bdf)))
    else $error("Half-bridge outputs not complementary");
  a_polarity_ace: assert property (mode == MODE_SINGLE && !shutdown_in |=> pins.level[0] == $past(pwm_level ^ pol_ace))
    else $error("Pin A polarity wrong");
  a_shut_ace_state: assert property (shutdown_in && ssa[1]
    |=> !pins.oe_n[0] && pins.level[0] == ($past(ssa[0]) ^ $past(pol_ace)))
    else $error("A/C/E shutdown drive wrong");
  a_shut_bdf_float: assert property (shutdown_in && !ssb[1] |=> pins.oe_n[1] && pins.oe_n[3] && pins.oe_n[5])
    else $error("B/D/F not floating in shutdown");
  a_variant_fields: assert property ((st_reg.ctrl & ~CTRL_WMASK) == 16'h0000)
    else $error("Absent control bit is set");
  a_shut_held: assert property (shutdown_in && $past(shutdown_in) && $stable(st_reg.ctrl) |=> $stable(pins))
    else $error("Shutdown state not held");
  // A latched trigger must free the pins one edge later even with the hold bit still set
  a_trigger_release: assert property (hold_off && trigger_in ##1 triggered_mode_enable && !shutdown_in
    && mode == MODE_SINGLE |=> !pins.oe_n[0])
    else $error("Pin still held after trigger");
  a_oneshot_extend: assert property (st_reg.os_active && time_base_tick && st_reg.os_rem != 3'h0
    |=> st_reg.os_active)
    else $error("One-shot ended before its extension");
  a_shut_bdf_inactive: assert property (shutdown_in && ssb == SHUT_INACTIVE
    |=> !pins.oe_n[1] && pins.level[1] == $past(pol_bdf))
    else $error("B/D/F inactive shutdown drive wrong");

  c_shutdown_entry: cover property (!shutdown_in ##1 shutdown_in ##1 shutdown_in);
  c_oneshot_long: cover property ($fell(st_reg.os_active) && os_len_reg == 3'h7);
  c_trigger_release: cover property (hold_off ##1 !hold_off && triggered_mode_enable);
  c_scan_wrap: cover property (mode == MODE_SCAN && st_reg.scan_idx == SCAN_LAST && time_base_tick);

endmodule

`default_nettype wire

// File: bench/cpoc_load_model.sv
// Model of the external power stage driven by the six output pins
`timescale 1ns/1ps
`default_nettype none

module cpoc_load_model
  import cpoc_pkg::*;
(
  input  wire cpoc_pkg::cpoc_pins_t pins,
  output wire logic [5:0]           pad
);
  // Pull-downs on the load side: a released pin reads low, never the last driven value
  assign pad = ~pins.oe_n & pins.level;
endmodule

`default_nettype wire

// File: bench/cpoc_output_control_tb.sv
// Self-checking bench for the compare output-control stage
`timescale 1ns/1ps
`default_nettype none

module cpoc_output_control_tb;
  import cpoc_pkg::*;
  logic        aclk = 0, aresetn = 0;
  logic [7:0]  s_axi_awaddr = 0, s_axi_araddr = 0;
  logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd_d, lfsr = 32'h2fa2e0d8;
  logic [3:0]  s_axi_wstrb = 0;
  logic        time_base_tick = 0, pwm_level = 0, one_shot_start = 0;
  logic        triggered_mode_enable = 0, trigger_in = 0, shutdown_in = 0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, one_shot_active;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  cpoc_pins_t  pins;
  logic [5:0]  pad;
  int          miscompares = 0, total_checks = 0, cyc = 0;
  // Per mode: pin carrying pwm, pin held on, pin carrying inverse pwm (-1 none)
  // No tick has come before the mode test, so push-pull phase and scan index are still 0
  int          pw[8] = '{0, 0, 0, -1, 1, 3, 0, -1};
  int          on[8] = '{-1, -1, -1, -1, 2, 0, -1, -1};
  int          iv[8] = '{-1, -1, 1, -1, -1, -1, -1, -1};

  always #4 aclk = ~aclk;

  cpoc_output_control dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .time_base_tick, .pwm_level, .one_shot_start, .triggered_mode_enable, .trigger_in, .shutdown_in,
    .pins, .one_shot_active);
  cpoc_load_model load_u (.pins, .pad);

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      end_of_test();
    end
  end

  task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t bus got %h exp %h", $time, got, exp);
    end
  endtask

  // Pad level is judged through the load, so a released pin must read low
  task automatic chk_pin(input int i, input logic oe, input logic lv);
    total_checks++;
    if (pins.oe_n[i] !== oe || pad[i] !== (oe ? 1'b0 : lv)) begin
      miscompares++;
      $display("CHECK FAILED %0t pin %0d oe_n %b pad %b", $time, i, pins.oe_n[i], pad[i]);
    end
  endtask

  function automatic logic pol(input logic [15:0] c, input int i);
    return (i % 2) ? c[POL_BDF_BIT] : c[POL_ACE_BIT];
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready) begin
        ad = 1;
        s_axi_awvalid <= 0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1;
        s_axi_wvalid <= 0;
      end
    end
    s_axi_bready <= 1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 0;
    s_axi_rready <= 1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    rd_d = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [15:0] c;
    logic [2:0]  ns[3];
    int          k, n;
    ns = '{3'h0, 3'h3, 3'h7};
    step(3);
    for (int i = 0; i < 6; i++) chk_pin(i, 1'b1, 1'b0);
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    rd(ADDR_CTRL);
    chk_bus(rd_d, {16'h0, CTRL_RESET});
    $display("test reset done");
    repeat (4) begin
      lfsr = nxt(lfsr);
      wr(ADDR_CTRL, lfsr);
      chk_bus({30'h0, rsp}, {30'h0, RESP_OKAY});
      rd(ADDR_CTRL);
      chk_bus(rd_d, lfsr & {16'h0, CTRL_WMASK});
    end
    wr(8'h08, 32'hffff);
    chk_bus({30'h0, rsp}, {30'h0, RESP_SLVERR});
    rd(8'h08);
    chk_bus({rd_d[31:2], rsp}, {30'h0, RESP_SLVERR});
    chk_bus(rd_d, 32'h0);
    $display("test regs done");
    k = 0;
    for (int m = 0; m < 7; m++) begin
      if (m == 3) continue;
      lfsr = nxt(lfsr);
      c = {5'h0, m[2:0], 2'h0, lfsr[1:0], k[1:0], ~k[1:0]};
      k++;
      wr(ADDR_CTRL, {16'h0, c});
      shutdown_in <= 1;
      // First look lands on the edge right after detection, second one later
      repeat (2) begin
        step(1);
        for (int i = 0; i < 6; i++) chk_pin(i, ~c[SSA_LSB + 1 - 2 * (i % 2)], c[SSA_LSB - 2 * (i % 2)] ^ pol(c, i));
        step(3);
      end
      @(posedge aclk);
      shutdown_in <= 0;
      pwm_level <= lfsr[7];
      step(2);
      if (pw[m] >= 0) chk_pin(pw[m], 1'b0, lfsr[7] ^ pol(c, pw[m]));
      if (on[m] >= 0) chk_pin(on[m], 1'b0, ~pol(c, on[m]));
      if (iv[m] >= 0) chk_pin(iv[m], 1'b0, ~lfsr[7] ^ pol(c, iv[m]));
    end
    wr(ADDR_CTRL, 32'h0700);
    step(2);
    for (int i = 0; i < 6; i++) chk_pin(i, 1'b1, 1'b0);
    $display("test modes done");
    wr(ADDR_CTRL, 32'h8000);
    triggered_mode_enable <= 1;
    pwm_level <= 1;
    step(3);
    chk_pin(0, 1'b1, 1'b0);
    @(posedge aclk);
    trigger_in <= 1;
    @(posedge aclk);
    trigger_in <= 0;
    step(1);
    chk_pin(0, 1'b0, 1'b1);
    @(posedge aclk);
    triggered_mode_enable <= 0;
    wr(ADDR_CTRL, 32'h0);
    triggered_mode_enable <= 1;
    step(2);
    chk_pin(0, 1'b0, 1'b1);
    $display("test trigger done");
    for (int j = 0; j < 3; j++) begin
      wr(ADDR_CTRL, {17'h0, ns[j], 12'h0});
      one_shot_start <= 1;
      @(posedge aclk);
      one_shot_start <= 0;
      #1;
      chk_bus({31'h0, one_shot_active}, 32'h1);
      n = 0;
      do begin
        @(posedge aclk);
        time_base_tick <= 1;
        @(posedge aclk);
        time_base_tick <= 0;
        n++;
        #1;
      end while (one_shot_active === 1'b1 && n < 12);
      chk_bus(n, ns[j] + 1);
    end
    $display("test oneshot done");
    end_of_test();
  end
endmodule

`default_nettype wire
